// File: spl_pkg.sv
// package: register map, field layout, timing and types for the system pll control block
package spl_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00; // doubler, gpio route
  localparam logic [7:0] REG_FBDIV   = 8'h04; // feedback divider
  localparam logic [7:0] REG_REFM_LO = 8'h08; // reference numerator [31:0]
  localparam logic [7:0] REG_REFM_HI = 8'h0c; // reference numerator [47:32]
  localparam logic [7:0] REG_REFN    = 8'h10; // reference denominator
  localparam logic [7:0] REG_STATUS  = 8'h14; // live state
  localparam logic [7:0] REG_INTSTAT = 8'h18; // sticky events, read only
  localparam logic [7:0] REG_INTCLR  = 8'h1c; // write one to clear
  localparam logic [7:0] REG_INTEN   = 8'h20; // event enables
  localparam logic [7:0] REG_LOCKWIN = 8'h24; // derived window, read only
  localparam logic [7:0] REG_FWCTRL  = 8'h28; // firmware revision supplied

  // field widths and positions
  localparam int FBDIV_W    = 10;
  localparam int LEVEL_W    = 12;
  localparam int FRAC_M_W   = 48;
  localparam int FRAC_N_W   = 16;
  localparam int EVT_W      = 4;
  localparam int CTRL_DBL   = 0;
  localparam int CTRL_GPIO  = 1;
  localparam int FW_DONE    = 0;
  localparam int ST_LOCK    = 0;
  localparam int ST_LOL     = 1;
  localparam int ST_BOOTED  = 2;
  localparam int ST_SRC_OTP = 3;
  localparam int ST_SRC_EEP = 4;
  localparam int ST_FWWAIT  = 5;
  localparam int ST_READY   = 6;
  localparam int EV_LOL     = 0;
  localparam int EV_LOCK    = 1;
  localparam int EV_BOOT    = 2;
  localparam int EV_REJECT  = 3;

  // divider range and reset values
  localparam logic [FBDIV_W-1:0] FBDIV_MIN = 10'd108;
  localparam logic [FBDIV_W-1:0] FBDIV_MAX = 10'd556;
  localparam logic [FBDIV_W-1:0] FBDIV_RST = 10'd108;
  localparam logic [FRAC_N_W-1:0] REFN_RST = 16'h0001;

  // lock window shaping
  localparam logic [LEVEL_W-1:0] LEVEL_MID   = 12'h800;
  localparam logic [LEVEL_W-1:0] WIN_BASE    = 12'h040;
  localparam int                 WIN_SHIFT   = 2;
  localparam logic [LEVEL_W-1:0] WIN_DBL_ADD = 12'h020;

  // timing
  localparam int CLK_MHZ       = 40;
  localparam int BOOT_WAIT_NS  = 2000;
  localparam int LOCK_SET_NS   = 1000;
  localparam int BOOT_CYC      = (BOOT_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYC      = (LOCK_SET_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W         = 8;

  // control fields as driven to the analog loop and loaded at boot
  typedef struct packed {
    logic               dblEn;
    logic [FBDIV_W-1:0] fbDiv;
  } spl_ctrl_t;

  // boot sequencer states
  typedef enum logic [2:0] {
    BOOT_WAIT,
    BOOT_LOAD,
    BOOT_FW,
    BOOT_RUN
  } spl_boot_t;

  // divider range check, used on load and on host write
  function automatic logic spl_div_ok(input logic [FBDIV_W-1:0] d);
    spl_div_ok = (d >= FBDIV_MIN) && (d <= FBDIV_MAX);
  endfunction : spl_div_ok

endpackage : spl_pkg

// File: spl_system_pll_ctrl.sv
// module: system pll control, boot load, lock window and loss-of-lock alarm
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module spl_system_pll_ctrl
  import spl_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // register port
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [31:0]       rdData,
  // boot sources (on-chip memory controllers, same clock)
  input  wire logic              otpEnable,
  input  wire logic              otpValid,
  input  wire spl_ctrl_t         otpCtrl,
  input  wire logic              eepEnable,
  input  wire logic              eepValid,
  input  wire spl_ctrl_t         eepCtrl,
  input  wire logic              fwRevPresent,
  input  wire logic              eepFwLoaded,
  // analog loop
  input  wire logic [LEVEL_W-1:0] loopLevel,
  output spl_ctrl_t              pllCtrl,
  output logic                   clkReady,
  // gpio status pin and interrupt
  output logic                   gpioOut,
  output logic                   gpioOe,
  output logic                   irq
);

  // control and configuration registers
  spl_ctrl_t               ctrl_q;        // live loop control fields
  logic                    gpioRoute_q;   // loss-of-lock to gpio
  logic [FRAC_M_W-1:0]     refM_q;        // reference rate numerator
  logic [FRAC_N_W-1:0]     refN_q;        // reference rate denominator
  logic [EVT_W-1:0]        intStat_q;     // sticky events
  logic [EVT_W-1:0]        intEn_q;       // event enables
  logic [31:0]             rdData_q;      // registered read data
  // boot sequencing
  spl_boot_t               boot_q;        // sequencer state
  logic [CNT_W-1:0]        bootCnt_q;     // power-up wait
  logic                    srcOtp_q;      // loaded from otp
  logic                    srcEep_q;      // loaded from eeprom
  // lock detection
  logic [LEVEL_W-1:0]      lvlMeta_q;     // first sync stage
  logic [LEVEL_W-1:0]      lvlSync_q;     // second sync stage
  logic [CNT_W-1:0]        lockCnt_q;     // in-window dwell
  logic                    locked_q;      // current lock state
  // derived signals
  logic [LEVEL_W-1:0]      winHalf;       // half width of window
  logic [LEVEL_W-1:0]      winLo;         // lower limit
  logic [LEVEL_W-1:0]      winHi;         // upper limit
  logic                    inWin;         // level inside window
  logic                    running;       // reset sequence finished
  logic                    fwWrite;       // host signals firmware loaded
  logic                    divWrite;      // host writes divider
  logic                    divReject;     // divider outside range
  logic [EVT_W-1:0]        evt;           // event pulses this cycle
  logic [EVT_W-1:0]        clrBits;       // clear request this cycle

  assign running = (boot_q == BOOT_RUN);

  // divider writes honoured only once the reset sequence is done
  assign divWrite  = wrStb && running && (addr == REG_FBDIV);
  assign divReject = divWrite && !spl_div_ok(wrData[FBDIV_W-1:0]);
  assign fwWrite   = wrStb && (boot_q == BOOT_FW) && (addr == REG_FWCTRL)
                     && wrData[FW_DONE];
  assign clrBits   = (wrStb && (addr == REG_INTCLR)) ? wrData[EVT_W-1:0] : '0;

  // lock window from divider and doubler; higher ratios get more room
  always_comb begin
    winHalf = WIN_BASE + LEVEL_W'(ctrl_q.fbDiv >> WIN_SHIFT);
    if (ctrl_q.dblEn) begin
      winHalf = winHalf + WIN_DBL_ADD;
    end
    winLo = LEVEL_MID - winHalf;
    winHi = LEVEL_MID + winHalf;
    inWin = (lvlSync_q >= winLo) && (lvlSync_q <= winHi);
  end

  // loop level arrives from the analog side, two stages before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvlMeta_q <= '0;
      lvlSync_q <= '0;
    end else if (ce) begin
      lvlMeta_q <= loopLevel;
      lvlSync_q <= lvlMeta_q;
    end
  end

  // boot sequencer: wait, load from a valid source, then firmware check
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_q    <= BOOT_WAIT;
      bootCnt_q <= '0;
    end else if (ce) begin
      case (boot_q)
        BOOT_WAIT: begin
          // give memory controllers time to report validity
          if (bootCnt_q == CNT_W'(BOOT_CYC - 1)) begin
            boot_q <= BOOT_LOAD;
          end else begin
            bootCnt_q <= bootCnt_q + 1'b1;
          end
        end
        BOOT_LOAD: begin
          boot_q <= BOOT_FW;
        end
        BOOT_FW: begin
          // stall here until the revision is present or supplied
          if (fwRevPresent || eepFwLoaded || fwWrite) begin
            boot_q <= BOOT_RUN;
          end
        end
        BOOT_RUN: begin
          boot_q <= BOOT_RUN;
        end
        default: begin
          boot_q <= BOOT_WAIT;
        end
      endcase
    end
  end

  // loop control fields: boot load, then host rewrites
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= '{dblEn: 1'b0, fbDiv: FBDIV_RST};
      srcOtp_q <= 1'b0;
      srcEep_q <= 1'b0;
    end else if (ce) begin
      if (boot_q == BOOT_LOAD) begin
        // otp wins when both are usable; bad divider contents count invalid
        if (otpEnable && otpValid && spl_div_ok(otpCtrl.fbDiv)) begin
          ctrl_q   <= otpCtrl;
          srcOtp_q <= 1'b1;
        end else if (eepEnable && eepValid && spl_div_ok(eepCtrl.fbDiv)) begin
          ctrl_q   <= eepCtrl;
          srcEep_q <= 1'b1;
        end
      end else if (running && wrStb && (addr == REG_CTRL)) begin
        ctrl_q.dblEn <= wrData[CTRL_DBL];
      end else if (divWrite && !divReject) begin
        ctrl_q.fbDiv <= wrData[FBDIV_W-1:0];
      end
    end
  end

  // other host registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioRoute_q <= 1'b0;
      refM_q      <= '0;
      refN_q      <= REFN_RST;
      intEn_q     <= '0;
    end else if (ce && wrStb) begin
      case (addr)
        REG_CTRL:    gpioRoute_q <= wrData[CTRL_GPIO];
        // reference rate kept as an exact fraction
        REG_REFM_LO: refM_q[31:0] <= wrData;
        REG_REFM_HI: refM_q[FRAC_M_W-1:32] <= wrData[FRAC_M_W-33:0];
        REG_REFN:    refN_q <= wrData[FRAC_N_W-1:0];
        REG_INTEN:   intEn_q <= wrData[EVT_W-1:0];
        default:     intEn_q <= intEn_q;
      endcase
    end
  end

  // lock detect: dwell before lock, drop at once when the window fails
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockCnt_q <= '0;
      locked_q  <= 1'b0;
    end else if (ce) begin
      if (!inWin || !running) begin
        lockCnt_q <= '0;
        locked_q  <= 1'b0;
      end else if (lockCnt_q == CNT_W'(LOCK_CYC - 1)) begin
        locked_q <= 1'b1;
      end else begin
        lockCnt_q <= lockCnt_q + 1'b1;
      end
    end
  end

  // event pulses
  always_comb begin
    evt            = '0;
    evt[EV_LOL]    = locked_q && running && !inWin;
    evt[EV_LOCK]   = !locked_q && inWin && running
                     && (lockCnt_q == CNT_W'(LOCK_CYC - 1));
    evt[EV_BOOT]   = (boot_q == BOOT_FW) && (fwRevPresent || eepFwLoaded || fwWrite);
    evt[EV_REJECT] = divReject;
  end

  // sticky status: a new event beats a simultaneous clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intStat_q <= '0;
    end else if (ce) begin
      intStat_q <= (intStat_q & ~clrBits) | evt;
    end
  end

  // read mux, data stands the cycle after the strobe only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (ce) begin
      rdData_q <= '0;
      if (rdStb) begin
        case (addr)
          REG_CTRL:    rdData_q <= {30'h0, gpioRoute_q, ctrl_q.dblEn};
          REG_FBDIV:   rdData_q <= {22'h0, ctrl_q.fbDiv};
          REG_REFM_LO: rdData_q <= refM_q[31:0];
          REG_REFM_HI: rdData_q <= {16'h0, refM_q[FRAC_M_W-1:32]};
          REG_REFN:    rdData_q <= {16'h0, refN_q};
          REG_STATUS: begin
            rdData_q[ST_LOCK]    <= locked_q;
            rdData_q[ST_LOL]     <= !locked_q;
            rdData_q[ST_BOOTED]  <= (boot_q == BOOT_FW) || running;
            rdData_q[ST_SRC_OTP] <= srcOtp_q;
            rdData_q[ST_SRC_EEP] <= srcEep_q;
            rdData_q[ST_FWWAIT]  <= (boot_q == BOOT_FW);
            rdData_q[ST_READY]   <= clkReady;
          end
          REG_INTSTAT: rdData_q <= {28'h0, intStat_q};
          REG_INTEN:   rdData_q <= {28'h0, intEn_q};
          REG_LOCKWIN: rdData_q <= {4'h0, winHi, 4'h0, winLo};
          // write-only clear and unmapped offsets read zero
          default:     rdData_q <= '0;
        endcase
      end
    end
  end

  // outputs
  assign rdData   = rdData_q;
  assign pllCtrl  = ctrl_q;
  // dependent clocks released only after lock
  assign clkReady = locked_q && running;
  // gpio shows loss of lock, driven only when routed
  assign gpioOe   = gpioRoute_q;
  assign gpioOut  = gpioRoute_q && !locked_q;
  assign irq      = |(intStat_q & intEn_q);

endmodule : spl_system_pll_ctrl

// File: spl_far_model.sv
// far side model: analog loop control level and serial eeprom boot image
`timescale 1ns/1ps
module spl_far_model
  import spl_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // steering from the bench
  input  wire logic               inWin,
  // loop level and eeprom image
  output logic      [LEVEL_W-1:0] loopLevel,
  output logic                    eepValid,
  output spl_ctrl_t               eepCtrl
);
  // settled loop sits mid window; an unsettled one rails low, outside any window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      loopLevel <= 12'h000;
    else
      loopLevel <= inWin ? LEVEL_MID : 12'h000;
  end
  // image keeps the pll in its tuning range: doubled crystal, divider 270
  assign eepValid = 1'b1;
  assign eepCtrl  = '{dblEn: 1'b1, fbDiv: 10'd270};
endmodule : spl_far_model

// File: spl_ctrl_properties.sv
// checker: lock, alarm and divider properties at the block ports
`timescale 1ns/1ps
module spl_ctrl_checker
  import spl_pkg::*;
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // register port
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wrData,
  input wire logic               wrStb,
  input wire logic               rdStb,
  input wire logic [31:0]        rdData,
  // loop and status
  input wire logic [LEVEL_W-1:0] loopLevel,
  input wire spl_ctrl_t          pllCtrl,
  input wire logic               clkReady,
  input wire logic               gpioOut,
  input wire logic               gpioOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] nearCnt_q; // run of raw levels inside the widest window
  // widest window is 0x800 +/- 0xeb, so a real lock always follows a long run here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      nearCnt_q <= 8'h00;
    else if (loopLevel < 12'h715 || loopLevel > 12'h8eb)
      nearCnt_q <= 8'h00;
    else if (nearCnt_q != 8'hff)
      nearCnt_q <= nearCnt_q + 8'h01;
  end
  a_gpio_route: assert property (gpioOut |-> gpioOe)
    else $error("gpio driven without route");
  a_gpio_alarm: assert property (clkReady |-> !gpioOut)
    else $error("alarm pin set while locked");
  a_lost_level: assert property ((loopLevel == 12'h000) [*5] |-> !clkReady)
    else $error("ready kept with level far outside");
  a_lock_dwell: assert property ($rose(clkReady) |-> $past(nearCnt_q, 3) >= 8'd36)
    else $error("lock declared without settling");
  a_reset_values: assert property ($fell(rst) |-> pllCtrl == {1'b0, FBDIV_RST} && !clkReady)
    else $error("control not at reset value");
  a_div_range: assert property (pllCtrl.fbDiv >= FBDIV_MIN && pllCtrl.fbDiv <= FBDIV_MAX)
    else $error("divider out of range");
  a_div_write: assert property (wrStb && addr == REG_FBDIV && clkReady && wrData >= 32'd108
    && wrData <= 32'd556 |=> pllCtrl.fbDiv == $past(wrData[9:0]))
    else $error("divider write not applied");
  a_read_idle: assert property (!$past(rdStb) |-> rdData == 32'h0)
    else $error("read data outside read slot");
endmodule : spl_ctrl_checker

bind spl_system_pll_ctrl spl_ctrl_checker i_spl_ctrl_checker (
  .mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .loopLevel(loopLevel), .pllCtrl(pllCtrl), .clkReady(clkReady),
  .gpioOut(gpioOut), .gpioOe(gpioOe));

// File: tb_top.sv
// testbench: boot sources, host access, lock, alarm and interrupt
`timescale 1ns/1ps
module tb_top
  import spl_pkg::*;
;
  logic mclk = 0, rst = 1, ce = 1, wrStb = 0, rdStb = 0, inWin = 0;
  logic otpEnable = 0, otpValid = 0, eepEnable = 1, fwRevPresent = 0, eepFwLoaded = 0;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wrData = 32'h0, rdData, rdv;
  spl_ctrl_t   otpCtrl = '{dblEn: 1'b0, fbDiv: 10'd300}, eepCtrl, pllCtrl;
  logic [LEVEL_W-1:0] loopLevel, half;
  logic eepValid, clkReady, gpioOut, gpioOe, irq;
  logic [9:0] divTab [4] = '{10'd107, 10'd556, 10'd557, 10'd108}, expDiv;
  int errors = 0, samples_checked = 0, n;
  always #12.5 mclk = ~mclk;
  spl_far_model i_spl_far_model (.mclk(mclk), .rst(rst), .inWin(inWin),
    .loopLevel(loopLevel), .eepValid(eepValid), .eepCtrl(eepCtrl));
  spl_system_pll_ctrl i_spl_system_pll_ctrl (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .otpEnable(otpEnable),
    .otpValid(otpValid), .otpCtrl(otpCtrl), .eepEnable(eepEnable), .eepValid(eepValid),
    .eepCtrl(eepCtrl), .fwRevPresent(fwRevPresent), .eepFwLoaded(eepFwLoaded),
    .loopLevel(loopLevel), .pllCtrl(pllCtrl), .clkReady(clkReady), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .irq(irq));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wrStb  <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge mclk);
    wrStb <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    rdStb <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 rdv = rdData;
  endtask : rd
  // reset for four cycles, then past the boot wait and load
  task automatic boot();
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (90) @(posedge mclk);
    #1;
  endtask : boot
  // bounded wait for ready, n counts cycles
  task automatic wait_ready();
    n = 0;
    while (clkReady !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : wait_ready
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  initial begin
    @(posedge mclk);
    #1 chk("reset ctrl", pllCtrl, {1'b0, FBDIV_RST});
    boot();
    chk("eeprom image", pllCtrl, {1'b1, 10'd270});
    rd(REG_STATUS);
    chk("boot status", rdv & 32'h3c, 32'h34);
    wr(REG_FBDIV, 32'd200);
    wr(8'h30, 32'h1); // unmapped place
    chk("div before run", pllCtrl, {1'b1, 10'd270});
    wr(REG_FWCTRL, 32'h1);
    inWin <= 1'b1;
    wait_ready();
    chk("lock dwell", {31'h0, n >= LOCK_CYC}, 32'h1);
    chk("ready", clkReady, 1'b1);
    $display("test boot done");
    wr(REG_CTRL, 32'h2);
    chk("route, no doubler", {gpioOe, gpioOut, pllCtrl.dblEn}, 3'b100);
    wr(REG_REFM_LO, 32'h89ab_cdef);
    wr(REG_REFM_HI, 32'hffff_0123);
    wr(REG_REFN, 32'h5555_009e);
    rd(REG_REFM_HI);
    chk("numerator high", rdv, 32'h0000_0123);
    rd(REG_REFN);
    chk("denominator", rdv, 32'h0000_009e);
    expDiv = 10'd270;
    foreach (divTab[i]) begin
      wr(REG_FBDIV, {22'h0, divTab[i]});
      if (divTab[i] >= FBDIV_MIN && divTab[i] <= FBDIV_MAX)
        expDiv = divTab[i];
      chk("divider", pllCtrl.fbDiv, expDiv);
    end
    rd(REG_INTSTAT);
    chk("reject event", rdv[EV_REJECT], 1'b1);
    chk("sticky events", rdv[EVT_W-1:0], 4'he);
    half = WIN_BASE + (12'd108 >> WIN_SHIFT);
    rd(REG_LOCKWIN);
    chk("window", rdv, {4'h0, LEVEL_MID + half, 4'h0, LEVEL_MID - half});
    $display("test registers done");
    wr(REG_INTEN, 32'h1);
    inWin <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("alarm pins", {clkReady, gpioOut, irq}, 3'b011);
    rd(REG_STATUS);
    chk("lol status", rdv[ST_LOL:ST_LOCK], 2'b10);
    wr(REG_INTEN, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(REG_INTEN, 32'h1);
    chk("irq back", irq, 1'b1);
    wr(REG_INTCLR, 32'h1);
    chk("irq cleared", irq, 1'b0);
    inWin <= 1'b1;
    wait_ready();
    chk("relock", {clkReady, gpioOut}, 2'b10);
    $display("test alarm done");
    otpEnable    <= 1'b1;
    otpValid     <= 1'b1;
    fwRevPresent <= 1'b1;
    boot();
    chk("otp image", pllCtrl, {1'b0, 10'd300});
    rd(REG_STATUS);
    chk("otp status", rdv & 32'h3c, 32'h0c);
    $display("test otp boot done");
    print_verdict();
  end
endmodule : tb_top
